// file: tcr_pkg.sv
// Shared constants and types for the trace capture readout block
package tcr_pkg;

  // Register byte addresses
  localparam logic [4:0] ADDR_CMD = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_ERROR = 5'h08;
  localparam logic [4:0] ADDR_DURATION = 5'h0C;
  localparam logic [4:0] ADDR_DISP_PTS = 5'h10;

  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SFX_LSB = 4;
  localparam int CMD_BOOL_BIT = 6;
  localparam int CMD_PRM_LSB = 8;
  localparam int CMD_SERIAL_BIT = 12;

  // Status word fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_CAP_LSB = 1;
  localparam int ST_UNIT_LSB = 3;
  localparam int ST_ANSWER_BIT = 5;
  localparam int ST_DUAL_BIT = 6;

  // Command opcodes
  localparam logic [2:0] OP_STATE_SET = 3'h0;
  localparam logic [2:0] OP_STATE_QRY = 3'h1;
  localparam logic [2:0] OP_UNIT_SET = 3'h2;
  localparam logic [2:0] OP_UNIT_QRY = 3'h3;
  localparam logic [2:0] OP_DATA_QRY = 3'h4;

  // Channel suffix codes
  localparam logic [1:0] SFX_NONE = 2'h0;
  localparam logic [1:0] SFX_CH_B = 2'h2;
  localparam logic [1:0] SFX_BAD = 2'h3;

  // Resolution and unit parameter codes
  localparam logic [1:0] RES_FULL = 2'h0;
  localparam logic [1:0] RES_THOU = 2'h1;
  localparam logic [1:0] RES_DISP = 2'h2;
  localparam logic [1:0] UNIT_DBM = 2'h0;
  localparam logic [1:0] UNIT_WATT = 2'h1;

  // Error codes, two's complement
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_UNDEF_HEADER = 16'hFF8F;
  localparam logic [15:0] ERR_SUFFIX_RANGE = 16'hFF8E;
  localparam logic [15:0] ERR_ILLEGAL_PARAM = 16'hFF20;
  localparam logic [15:0] ERR_SETTINGS_CONFLICT = 16'hFF23;
  localparam logic [15:0] ERR_HW_MISSING = 16'hFF0F;

  // Point counts and reset values
  localparam logic [15:0] THOUSAND_POINTS = 16'h03E8;
  localparam logic [15:0] DURATION_RST = 16'h0100;
  localparam logic [15:0] DISP_PTS_RST = 16'h00F0;

  // Block framing characters
  localparam logic [7:0] CHR_HASH = 8'h23;
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_LF = 8'h0A;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_DIV = 10'h002,
    ST_HASH = 10'h004,
    ST_NDIG = 10'h008,
    ST_CONV = 10'h010,
    ST_DIGIT = 10'h020,
    ST_RD = 10'h040,
    ST_LOAD = 10'h080,
    ST_BYTES = 10'h100,
    ST_LF = 10'h200
  } tcr_state_t;

endpackage : tcr_pkg

// file: tcr_capture_mem.sv
// Capture buffer memory with registered read data
`timescale 1ns/10ps
module tcr_capture_mem #(
  parameter int DW = 32,
  parameter int AW = 13
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : tcr_capture_mem

// file: tcr_trace_readout.sv
// Trace capture control and length-prefixed trace block readout
`timescale 1ns/10ps
// Behaviour
// RQ1: Trace readout query arriving over a serial interface is refused.
// RQ2: Readout framed as definite-length block: hash, digit count, byte count, payload.
// RQ3: Each trace point is one 32-bit float, four payload bytes.
// RQ4: Point bytes are sent most significant byte first.
// RQ5: A line feed follows the last payload byte of each block.
// RQ6: Trace encoding ignores the general output number format.
// RQ7: Full-rate readout returns the whole buffer; point count is the duration setting.
// RQ8: Thousand-point readout decimates the buffer to exactly 1000 points.
// RQ9: Display readout decimates to the display point count.
// RQ10: Readout with capture disabled on that channel gives settings conflict.
// RQ11: Host picks a non free-running trigger and turns continuous arming off first.
// RQ12: Per-channel capture enable set by boolean command; query answers 1 or 0.
// RQ13: Reset clears capture enable on every channel.
// RQ14: Capture enable with no compatible sensor gives hardware missing.
// RQ15: Capture enable with sensor in averaging mode gives settings conflict.
// RQ16: Per-channel unit selection dBm or watts, settable and queryable.
// RQ17: Reset sets each channel's unit to dBm.
// RQ18: Suffix 1 or none means channel A, suffix 2 channel B.
// RQ19: Channel B commands on a single-channel unit give suffix out of range.
// RQ20: Trace commands accepted only with a compatible sensor on that channel.
// RQ21: Bad resolution or unit parameter gives parameter error, settings unchanged.
module tcr_trace_readout #(
  parameter int DEPTH = 4096,
  parameter int PTS_W = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic dual_channel,
  input wire logic [1:0] sensor_present,
  input wire logic [1:0] sensor_averaging,
  input wire logic samp_valid,
  input wire logic samp_chan,
  input wire logic [31:0] samp_data,
  output logic [1:0] capture_enable,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int BW = PTS_W + 2;

  function automatic logic [BW-1:0] tcr_pow10(input logic [2:0] k);
    logic [BW-1:0] p;
    p = BW'(1);
    case (k)
      3'h1: p = BW'(10);
      3'h2: p = BW'(100);
      3'h3: p = BW'(1000);
      3'h4: p = BW'(10000);
      3'h5: p = BW'(100000);
      default: p = BW'(1);
    endcase
    return p;
  endfunction : tcr_pow10

  tcr_pkg::tcr_state_t state_r;
  logic [1:0] cap_en_r;
  logic [1:0] unit_r;
  logic answer_r;
  logic [15:0] err_r;
  logic [PTS_W-1:0] duration_r;
  logic [PTS_W-1:0] disp_pts_r;
  logic [31:0] reg_rdata_r;
  logic chan_r;
  logic [PTS_W-1:0] m_r;
  logic [PTS_W-1:0] q_r;
  logic [PTS_W-1:0] rem_r;
  logic [PTS_W-1:0] acc_r;
  logic [PTS_W-1:0] addr_r;
  logic [PTS_W-1:0] pt_cnt_r;
  logic [BW-1:0] dec_r;
  logic [2:0] k_r;
  logic [3:0] dig_r;
  logic [1:0] byte_idx_r;
  logic [31:0] word_r;
  logic [7:0] tx_byte_r;
  logic [PTS_W-1:0] wp_r [0:1];
  logic [31:0] rd_word;

  // Command decode
  wire idle = (state_r == tcr_pkg::ST_IDLE);
  wire cmd_go = reg_wr && (reg_addr == tcr_pkg::ADDR_CMD) && idle;
  wire [2:0] op = reg_wdata[tcr_pkg::CMD_OP_LSB +: 3];
  wire [1:0] sfx = reg_wdata[tcr_pkg::CMD_SFX_LSB +: 2];
  wire [1:0] prm = reg_wdata[tcr_pkg::CMD_PRM_LSB +: 2];
  wire bool_arg = reg_wdata[tcr_pkg::CMD_BOOL_BIT];
  wire via_serial = reg_wdata[tcr_pkg::CMD_SERIAL_BIT];
  wire cmd_chan = (sfx == tcr_pkg::SFX_CH_B); // RQ18
  wire is_data = (op == tcr_pkg::OP_DATA_QRY);
  wire op_bad = (op > tcr_pkg::OP_DATA_QRY);
  wire sfx_bad = (sfx == tcr_pkg::SFX_BAD) || (cmd_chan && !dual_channel); // RQ19
  wire [PTS_W-1:0] m_sel = (prm == tcr_pkg::RES_FULL) ? duration_r : // RQ7
                           (prm == tcr_pkg::RES_THOU) ? PTS_W'(tcr_pkg::THOUSAND_POINTS) : // RQ8
                           disp_pts_r; // RQ9
  wire unit_bad = (op == tcr_pkg::OP_UNIT_SET) && (prm > tcr_pkg::UNIT_WATT);
  wire res_bad = is_data && ((prm > tcr_pkg::RES_DISP) || (m_sel == '0));
  wire avg_mode = (op == tcr_pkg::OP_STATE_SET) && sensor_averaging[cmd_chan];

  // Error priority: header, interface, suffix, sensor, mode, parameter, capture state
  wire [15:0] cmd_err = op_bad ? tcr_pkg::ERR_UNDEF_HEADER :
                        (is_data && via_serial) ? tcr_pkg::ERR_UNDEF_HEADER : // RQ1
                        sfx_bad ? tcr_pkg::ERR_SUFFIX_RANGE : // RQ19
                        !sensor_present[cmd_chan] ? tcr_pkg::ERR_HW_MISSING : // RQ14 RQ20
                        avg_mode ? tcr_pkg::ERR_SETTINGS_CONFLICT : // RQ15
                        (unit_bad || res_bad) ? tcr_pkg::ERR_ILLEGAL_PARAM : // RQ21
                        (is_data && !cap_en_r[cmd_chan]) ? tcr_pkg::ERR_SETTINGS_CONFLICT : // RQ10
                        tcr_pkg::ERR_NONE;
  wire cmd_ok = cmd_go && (cmd_err == tcr_pkg::ERR_NONE);
  wire cmd_fail = cmd_go && (cmd_err != tcr_pkg::ERR_NONE);
  wire start_read = cmd_ok && is_data;

  // Block header arithmetic
  wire [BW-1:0] byte_cnt = {m_r, 2'b00}; // RQ3
  wire [2:0] ndig = 3'h1 + {2'h0, byte_cnt >= tcr_pow10(3'h1)} + {2'h0, byte_cnt >= tcr_pow10(3'h2)}
                    + {2'h0, byte_cnt >= tcr_pow10(3'h3)} + {2'h0, byte_cnt >= tcr_pow10(3'h4)}
                    + {2'h0, byte_cnt >= tcr_pow10(3'h5)};
  wire [BW-1:0] pow_k = tcr_pow10(k_r);
  wire conv_sub = (dec_r >= pow_k);

  // Decimation stepping: integer stride plus error accumulator
  wire [PTS_W:0] acc_sum = {1'b0, acc_r} + {1'b0, rem_r};
  wire acc_wrap = (acc_sum >= {1'b0, m_r});
  wire [PTS_W-1:0] acc_nxt = acc_wrap ? PTS_W'(acc_sum - {1'b0, m_r}) : acc_sum[PTS_W-1:0];
  wire [PTS_W-1:0] addr_nxt = addr_r + q_r + {{(PTS_W-1){1'b0}}, acc_wrap};
  wire last_pt = (pt_cnt_r == m_r - PTS_W'(1));
  wire sending = (state_r == tcr_pkg::ST_HASH) || (state_r == tcr_pkg::ST_NDIG) ||
                 (state_r == tcr_pkg::ST_DIGIT) || (state_r == tcr_pkg::ST_BYTES) ||
                 (state_r == tcr_pkg::ST_LF);
  wire take = sending && tx_ready;

  // Capture writes are frozen during a readout so the block stays self-consistent
  wire cap_wr = samp_valid && cap_en_r[samp_chan] && idle;
  wire mem_rd = (state_r == tcr_pkg::ST_RD);
  wire [AW:0] wr_addr = {samp_chan, wp_r[samp_chan][AW-1:0]};
  wire [AW:0] rd_addr = {chan_r, addr_r[AW-1:0]};

  assign tx_valid = sending;
  assign tx_data = tx_byte_r;
  assign capture_enable = cap_en_r;
  assign reg_rdata = reg_rdata_r;

  tcr_capture_mem #(
    .DW(32),
    .AW(AW + 1)
  ) u_mem (
    .core_clk(core_clk),
    .wr_en(cap_wr),
    .wr_addr(wr_addr),
    .wr_data(samp_data),
    .rd_en(mem_rd),
    .rd_addr(rd_addr),
    .rd_data(rd_word)
  );

  // Per-channel settings and capture pointer
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      wire hit = cmd_ok && (cmd_chan == ch[0]);
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
        begin
          cap_en_r[ch] <= 1'b0; // RQ13
          unit_r[ch] <= 1'b0; // RQ17
        end
        else if (hit && (op == tcr_pkg::OP_STATE_SET))
        begin
          cap_en_r[ch] <= bool_arg; // RQ12
        end
        else if (hit && (op == tcr_pkg::OP_UNIT_SET))
        begin
          unit_r[ch] <= (prm == tcr_pkg::UNIT_WATT); // RQ16
        end
      end
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
        begin
          wp_r[ch] <= '0;
        end
        else if (hit && (op == tcr_pkg::OP_STATE_SET))
        begin
          wp_r[ch] <= '0;
        end
        else if (cap_wr && (samp_chan == ch[0]))
        begin
          wp_r[ch] <= (wp_r[ch] + PTS_W'(1) >= duration_r) ? '0 : wp_r[ch] + PTS_W'(1);
        end
      end
    end
  endgenerate

  // Query answer and error register; a new error wins over a read-clear
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      answer_r <= 1'b0;
      err_r <= tcr_pkg::ERR_NONE;
    end
    else
    begin
      if (cmd_ok && (op == tcr_pkg::OP_STATE_QRY))
      begin
        answer_r <= cap_en_r[cmd_chan]; // RQ12
      end
      else if (cmd_ok && (op == tcr_pkg::OP_UNIT_QRY))
      begin
        answer_r <= unit_r[cmd_chan]; // RQ16
      end
      if (cmd_fail)
      begin
        err_r <= cmd_err;
      end
      else if (reg_rd && (reg_addr == tcr_pkg::ADDR_ERROR))
      begin
        err_r <= tcr_pkg::ERR_NONE;
      end
    end
  end

  // Plain settings registers and read port
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      duration_r <= PTS_W'(tcr_pkg::DURATION_RST);
      disp_pts_r <= PTS_W'(tcr_pkg::DISP_PTS_RST);
    end
    else if (reg_wr && (reg_addr == tcr_pkg::ADDR_DURATION))
    begin
      duration_r <= reg_wdata[PTS_W-1:0]; // RQ7
    end
    else if (reg_wr && (reg_addr == tcr_pkg::ADDR_DISP_PTS))
    begin
      disp_pts_r <= reg_wdata[PTS_W-1:0]; // RQ9
    end
  end

  wire [31:0] status_word = {25'h0, dual_channel, answer_r, unit_r, cap_en_r, !idle};
  wire [31:0] rd_mux = (reg_addr == tcr_pkg::ADDR_STATUS) ? status_word :
                       (reg_addr == tcr_pkg::ADDR_ERROR) ? {16'h0, err_r} :
                       (reg_addr == tcr_pkg::ADDR_DURATION) ? 32'(duration_r) :
                       (reg_addr == tcr_pkg::ADDR_DISP_PTS) ? 32'(disp_pts_r) :
                       32'h0000_0000;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      reg_rdata_r <= 32'h0000_0000;
    end
    else
    begin
      reg_rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Readout sequencer
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_r <= tcr_pkg::ST_IDLE;
      chan_r <= 1'b0;
      m_r <= '0;
      q_r <= '0;
      rem_r <= '0;
      acc_r <= '0;
      addr_r <= '0;
      pt_cnt_r <= '0;
      dec_r <= '0;
      k_r <= 3'h0;
      dig_r <= 4'h0;
      byte_idx_r <= 2'h0;
      word_r <= 32'h0000_0000;
      tx_byte_r <= 8'h00;
    end
    else
    begin
      unique case (state_r)
        tcr_pkg::ST_IDLE:
        begin
          if (start_read)
          begin
            chan_r <= cmd_chan;
            m_r <= m_sel;
            rem_r <= duration_r;
            q_r <= '0;
            acc_r <= '0;
            addr_r <= '0;
            pt_cnt_r <= '0;
            state_r <= tcr_pkg::ST_DIV;
          end
        end
        tcr_pkg::ST_DIV:
        begin
          if (rem_r >= m_r)
          begin
            rem_r <= rem_r - m_r;
            q_r <= q_r + PTS_W'(1);
          end
          else
          begin
            tx_byte_r <= tcr_pkg::CHR_HASH; // RQ2
            state_r <= tcr_pkg::ST_HASH;
          end
        end
        tcr_pkg::ST_HASH:
        begin
          if (take)
          begin
            tx_byte_r <= tcr_pkg::CHR_ZERO + {5'h0, ndig}; // RQ2
            state_r <= tcr_pkg::ST_NDIG;
          end
        end
        tcr_pkg::ST_NDIG:
        begin
          if (take)
          begin
            dec_r <= byte_cnt;
            k_r <= ndig - 3'h1;
            dig_r <= 4'h0;
            state_r <= tcr_pkg::ST_CONV;
          end
        end
        tcr_pkg::ST_CONV:
        begin
          if (conv_sub)
          begin
            dec_r <= dec_r - pow_k;
            dig_r <= dig_r + 4'h1;
          end
          else
          begin
            tx_byte_r <= tcr_pkg::CHR_ZERO + {4'h0, dig_r}; // RQ2
            state_r <= tcr_pkg::ST_DIGIT;
          end
        end
        tcr_pkg::ST_DIGIT:
        begin
          if (take)
          begin
            dig_r <= 4'h0;
            k_r <= k_r - 3'h1;
            state_r <= (k_r == 3'h0) ? tcr_pkg::ST_RD : tcr_pkg::ST_CONV;
          end
        end
        tcr_pkg::ST_RD:
        begin
          state_r <= tcr_pkg::ST_LOAD;
        end
        tcr_pkg::ST_LOAD:
        begin
          // Raw float word goes out unchanged whatever the number format elsewhere
          word_r <= {rd_word[23:0], 8'h00}; // RQ6
          tx_byte_r <= rd_word[31:24]; // RQ4
          byte_idx_r <= 2'h0;
          state_r <= tcr_pkg::ST_BYTES;
        end
        tcr_pkg::ST_BYTES:
        begin
          if (take)
          begin
            if (byte_idx_r == 2'h3)
            begin
              pt_cnt_r <= pt_cnt_r + PTS_W'(1);
              acc_r <= acc_nxt; // RQ8
              addr_r <= addr_nxt; // RQ9
              tx_byte_r <= tcr_pkg::CHR_LF; // RQ5
              state_r <= last_pt ? tcr_pkg::ST_LF : tcr_pkg::ST_RD;
            end
            else
            begin
              byte_idx_r <= byte_idx_r + 2'h1; // RQ3
              tx_byte_r <= word_r[31:24]; // RQ4
              word_r <= {word_r[23:0], 8'h00};
            end
          end
        end
        tcr_pkg::ST_LF:
        begin
          if (take)
          begin
            state_r <= tcr_pkg::ST_IDLE; // RQ5
          end
        end
        default:
        begin
          state_r <= tcr_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule : tcr_trace_readout

// file: tcr_trace_readout_assertions.sv
// Port-level checker for the trace capture readout block
`timescale 1ns/10ps
module tcr_trace_readout_assertions #(
  parameter int DEPTH = 4096,
  parameter int PTS_W = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic dual_channel,
  input wire logic [1:0] sensor_present,
  input wire logic [1:0] sensor_averaging,
  input wire logic samp_valid,
  input wire logic samp_chan,
  input wire logic [31:0] samp_data,
  input wire logic [1:0] capture_enable,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready
);
  wire cmd_wr = reg_wr && reg_addr == tcr_pkg::ADDR_CMD;
  wire [2:0] op = reg_wdata[2:0];
  // Suffix codes 0 and 1 both address channel A
  wire set_a = cmd_wr && op == tcr_pkg::OP_STATE_SET && !reg_wdata[5];
  // Only meaningful while no block is on its way out
  wire qry_a = cmd_wr && op == tcr_pkg::OP_DATA_QRY && !reg_wdata[5] && !tx_valid;
  wire b_single = cmd_wr && reg_wdata[5:4] == tcr_pkg::SFX_CH_B && !dual_channel;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_rdata_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data seen outside a read reply");
  chk_reset_clear: assert property (disable iff (1'b0) !reset_n |=> capture_enable == 2'h0 && !tx_valid)
    else $error("reset left capture or stream active");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("offered byte dropped or changed before taken");
  // Reset also clears the enables, and its last low edge may already have release in flight
  chk_cap_cause: assert property ($changed(capture_enable) |-> $past(cmd_wr) || !$past(reset_n))
    else $error("capture enable moved without a command");
  chk_no_sensor: assert property (set_a && !sensor_present[0] |=> $stable(capture_enable[0]))
    else $error("capture enable changed without a sensor");
  chk_avg_block: assert property (set_a && sensor_averaging[0] |=> $stable(capture_enable[0]))
    else $error("capture enable changed in averaging mode");
  chk_single_b: assert property (b_single |=> $stable(capture_enable))
    else $error("channel B command acted on a single unit");
  chk_serial_refuse: assert property (qry_a && reg_wdata[12] |=> !tx_valid [*8])
    else $error("serial readout produced bytes");
  chk_off_refuse: assert property (qry_a && !capture_enable[0] |=> !tx_valid [*8])
    else $error("readout with capture off produced bytes");
  cov_readout: cover property (qry_a && capture_enable[0]);
  cov_stall: cover property (tx_valid && !tx_ready);
  cov_lf: cover property (tx_valid && tx_ready && tx_data == tcr_pkg::CHR_LF);
endmodule : tcr_trace_readout_assertions

bind tcr_trace_readout tcr_trace_readout_assertions #(.DEPTH(DEPTH), .PTS_W(PTS_W)) chk_inst (
  .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dual_channel(dual_channel), .sensor_present(sensor_present),
  .sensor_averaging(sensor_averaging), .samp_valid(samp_valid), .samp_chan(samp_chan),
  .samp_data(samp_data), .capture_enable(capture_enable), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready)
);

// file: tcr_host_model.sv
// Remote host model that drains the trace byte stream
`timescale 1ns/10ps
module tcr_host_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] q[$];
  logic [7:0] stall_r;
  // Readouts are only asked for with a held event origin and continuous arming off
  // Slow mode stalls on a pseudo-random pattern so held bytes are exercised
  assign tx_ready = !slow || stall_r[0];
  always @(posedge core_clk)
  begin
    if (!reset_n)
      stall_r <= 8'h5A;
    else
      stall_r <= {stall_r[6:0], stall_r[7] ^ stall_r[5] ^ stall_r[4] ^ stall_r[3]};
    if (reset_n && tx_valid && tx_ready)
      q.push_back(tx_data);
  end
endmodule : tcr_host_model

// file: tcr_trace_readout_tb.sv
// Self-checking bench for the trace capture readout block
`timescale 1ns/10ps
module tcr_trace_readout_tb;
  localparam int N_PTS = 8;
  logic core_clk = 1'b0;
  logic reset_n, reg_wr, reg_rd, dual_channel, samp_valid, samp_chan, tx_valid, tx_ready, slow;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, samp_data, rd_v;
  logic [1:0] sensor_present, sensor_averaging, capture_enable, exp_unit, sfx;
  logic [7:0] tx_data;
  logic [15:0] seed;
  logic [31:0] buf_a[N_PTS];
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int checks_done = 0;

  always #20 core_clk = ~core_clk;

  tcr_trace_readout tcr_trace_readout_inst (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dual_channel(dual_channel), .sensor_present(sensor_present),
    .sensor_averaging(sensor_averaging), .samp_valid(samp_valid), .samp_chan(samp_chan),
    .samp_data(samp_data), .capture_enable(capture_enable), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready)
  );
  tcr_host_model tcr_host_model_inst (
    .core_clk(core_clk), .reset_n(reset_n), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready)
  );

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [31:0] cw(logic [2:0] op, logic [1:0] sf, logic b, logic [1:0] p, logic s);
    return {19'h0, s, 2'h0, p, 1'b0, b, sf, 1'b0, op};
  endfunction : cw

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is taken in the one cycle after the strobe
  task automatic rchk(string nm, logic [4:0] a, logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
    chk(nm, e, rd_v);
  endtask : rchk

  task automatic err_case(logic [31:0] c, logic [1:0] p, logic [1:0] av, logic d, logic [15:0] e);
    sensor_present <= p;
    sensor_averaging <= av;
    dual_channel <= d;
    wr(tcr_pkg::ADDR_CMD, c);
    rchk("error code", tcr_pkg::ADDR_ERROR, {16'h0, e});
    rchk("status kept", tcr_pkg::ADDR_STATUS, {25'h0, d, 6'h0});
  endtask : err_case

  // Point i comes from buffer index floor(i * N / M)
  task automatic readout(logic [1:0] res, int m);
    string hs;
    logic [31:0] v;
    hs = $sformatf("%0d", 4 * m);
    exp_q = {tcr_pkg::CHR_HASH, tcr_pkg::CHR_ZERO + 8'(hs.len())};
    foreach (hs[i])
      exp_q.push_back(hs[i]);
    for (int i = 0; i < m; i++)
    begin
      v = buf_a[(i * N_PTS) / m];
      for (int b = 3; b >= 0; b--)
        exp_q.push_back(v[8 * b +: 8]);
    end
    exp_q.push_back(tcr_pkg::CHR_LF);
    tcr_host_model_inst.q = {};
    wr(tcr_pkg::ADDR_CMD, cw(tcr_pkg::OP_DATA_QRY, tcr_pkg::SFX_NONE, 1'b0, res, 1'b0));
    for (int k = 0; k < 40000 && tcr_host_model_inst.q.size() < exp_q.size(); k++)
      @(posedge core_clk);
    // Extra cycles catch bytes sent after the terminator
    repeat (20) @(posedge core_clk);
    chk("block length", 32'(exp_q.size()), 32'(tcr_host_model_inst.q.size()));
    foreach (exp_q[i])
      if (i < tcr_host_model_inst.q.size())
        chk("block byte", {24'h0, exp_q[i]}, {24'h0, tcr_host_model_inst.q[i]});
    $display("test readout of %0d points done", m);
  endtask : readout

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end

  initial
  begin
    {reset_n, reg_wr, reg_rd, samp_valid, samp_chan, slow, reg_addr} = '0;
    {reg_wdata, samp_data, sensor_averaging, exp_unit} = '0;
    sensor_present = 2'h3;
    dual_channel = 1'b1;
    seed = 16'h004C;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    rchk("status reset", tcr_pkg::ADDR_STATUS, 32'h40);
    rchk("duration reset", tcr_pkg::ADDR_DURATION, {16'h0, tcr_pkg::DURATION_RST});
    rchk("display reset", tcr_pkg::ADDR_DISP_PTS, {16'h0, tcr_pkg::DISP_PTS_RST});
    rchk("unmapped read", 5'h14, 32'h0);
    $display("test reset done");
    err_case(cw(tcr_pkg::OP_DATA_QRY, 2'h0, 1'b0, 2'h0, 1'b0), 2'h3, 2'h0, 1'b1, tcr_pkg::ERR_SETTINGS_CONFLICT);
    err_case(cw(tcr_pkg::OP_DATA_QRY, 2'h0, 1'b0, 2'h0, 1'b1), 2'h3, 2'h0, 1'b1, tcr_pkg::ERR_UNDEF_HEADER);
    err_case(cw(tcr_pkg::OP_STATE_SET, 2'h0, 1'b1, 2'h0, 1'b0), 2'h2, 2'h0, 1'b1, tcr_pkg::ERR_HW_MISSING);
    err_case(cw(tcr_pkg::OP_UNIT_SET, 2'h0, 1'b0, 2'h1, 1'b0), 2'h2, 2'h0, 1'b1, tcr_pkg::ERR_HW_MISSING);
    err_case(cw(tcr_pkg::OP_STATE_SET, 2'h1, 1'b1, 2'h0, 1'b0), 2'h3, 2'h1, 1'b1, tcr_pkg::ERR_SETTINGS_CONFLICT);
    err_case(cw(tcr_pkg::OP_STATE_SET, 2'h2, 1'b1, 2'h0, 1'b0), 2'h3, 2'h0, 1'b0, tcr_pkg::ERR_SUFFIX_RANGE);
    err_case(cw(tcr_pkg::OP_UNIT_SET, 2'h0, 1'b0, 2'h2, 1'b0), 2'h3, 2'h0, 1'b1, tcr_pkg::ERR_ILLEGAL_PARAM);
    err_case(cw(tcr_pkg::OP_DATA_QRY, 2'h0, 1'b0, 2'h3, 1'b0), 2'h3, 2'h0, 1'b1, tcr_pkg::ERR_ILLEGAL_PARAM);
    err_case(cw(3'h5, 2'h0, 1'b0, 2'h0, 1'b0), 2'h3, 2'h0, 1'b1, tcr_pkg::ERR_UNDEF_HEADER);
    err_case(cw(tcr_pkg::OP_UNIT_SET, 2'h3, 1'b0, 2'h1, 1'b0), 2'h3, 2'h0, 1'b1, tcr_pkg::ERR_SUFFIX_RANGE);
    rchk("error cleared", tcr_pkg::ADDR_ERROR, 32'h0);
    chk("refused bytes", 32'h0, 32'(tcr_host_model_inst.q.size()));
    $display("test errors done");
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      sfx = seed[1] ? tcr_pkg::SFX_CH_B : {1'b0, seed[2]};
      exp_unit[seed[1]] = seed[0];
      wr(tcr_pkg::ADDR_CMD, cw(tcr_pkg::OP_UNIT_SET, sfx, 1'b0, {1'b0, seed[0]}, 1'b0));
      wr(tcr_pkg::ADDR_CMD, cw(tcr_pkg::OP_UNIT_QRY, sfx, 1'b0, 2'h0, 1'b0));
      rchk("unit status", tcr_pkg::ADDR_STATUS, {25'h0, 1'b1, seed[0], exp_unit, 3'h0});
    end
    // Channel A is put in watts first so a wrongly taken bad unit would show
    exp_unit[0] = 1'b1;
    wr(tcr_pkg::ADDR_CMD, cw(tcr_pkg::OP_UNIT_SET, 2'h0, 1'b0, 2'h1, 1'b0));
    wr(tcr_pkg::ADDR_CMD, cw(tcr_pkg::OP_UNIT_SET, 2'h0, 1'b0, 2'h3, 1'b0));
    rchk("bad unit kept", tcr_pkg::ADDR_STATUS, {25'h0, 1'b1, seed[0], exp_unit, 3'h0});
    $display("test units done");
    wr(tcr_pkg::ADDR_DURATION, N_PTS);
    wr(tcr_pkg::ADDR_DISP_PTS, 32'h3);
    wr(tcr_pkg::ADDR_CMD, cw(tcr_pkg::OP_STATE_SET, 2'h1, 1'b1, 2'h0, 1'b0));
    wr(tcr_pkg::ADDR_CMD, cw(tcr_pkg::OP_STATE_QRY, 2'h0, 1'b0, 2'h0, 1'b0));
    rchk("capture status", tcr_pkg::ADDR_STATUS, {25'h0, 2'h3, exp_unit, 3'h2});
    // Ten samples into eight slots checks the pointer wrap
    for (int i = 0; i < 10; i++)
    begin
      seed = lfsr(seed);
      buf_a[i % N_PTS] = {seed, ~seed};
      @(posedge core_clk);
      samp_valid <= 1'b1;
      samp_data <= {seed, ~seed};
    end
    @(posedge core_clk);
    samp_valid <= 1'b0;
    readout(tcr_pkg::RES_FULL, N_PTS);
    slow <= 1'b1;
    readout(tcr_pkg::RES_THOU, 1000);
    slow <= 1'b0;
    readout(tcr_pkg::RES_DISP, 3);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    chk("capture enable", 32'h0, {30'h0, capture_enable});
    rchk("status after reset", tcr_pkg::ADDR_STATUS, 32'h40);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : tcr_trace_readout_tb
